// ---- core/uefa_cfg.svh ----
`ifndef UEFA_CFG_SVH
`define UEFA_CFG_SVH

// endpoint set and shared store
`define UEFA_NUM_EP 16
`define UEFA_STORE_BYTES 16'd2462
`define UEFA_CTRL_BYTES 12'd64
`define UEFA_IDX_CTRL_OUT 4'h0
`define UEFA_IDX_CTRL_IN 4'h1
`define UEFA_IDX_FIRST_CFG 4'h2
`define UEFA_NONISO_CODES 4'h4

// endpoint_config_reg field positions and reset value
`define UEFA_ECR_EN 7
`define UEFA_ECR_DBL 6
`define UEFA_ECR_DIR 5
`define UEFA_ECR_ISO 4
`define UEFA_ECR_RST 8'h00

// controller register byte offsets
`define UEFA_REG_ECR 5'h00
`define UEFA_REG_DMA 5'h04
`define UEFA_REG_SEL 5'h08
`define UEFA_REG_DATA 5'h0c
`define UEFA_REG_STAT 5'h10

// status bit positions
`define UEFA_ST_ALLOC_ERR 16
`define UEFA_ST_ACC_ERR 17
`define UEFA_ST_EMPTY 18
`define UEFA_ST_FULL 19

// command queue in front of the link
`define UEFA_FIFO_DEPTH 16

`endif

// ---- core/uefa_pkg.sv ----
package uefa_pkg;
  `include "uefa_cfg.svh"

  typedef logic [3:0] uefa_idx_t;
  typedef logic [11:0] uefa_len_t;
  typedef logic [15:0] uefa_sum_t;

  typedef struct packed {
    logic en;
    logic dbl;
    logic dir;
    logic iso;
    logic [3:0] size;
  } uefa_ecr_s;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_DONE
  } uefa_rd_e;
endpackage

// ---- core/uefa_link_if.sv ----
`timescale 1ns/1ps
interface uefa_link_if
  import uefa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i
);
  // configuration writes and dma selection
  logic cfg_wr;
  uefa_idx_t cfg_idx;
  logic [7:0] cfg_data;
  logic dma_en;
  uefa_idx_t dma_idx;
  // fifo access requests
  logic acc_valid;
  logic acc_ready;
  logic acc_write;
  logic acc_dma;
  uefa_idx_t acc_idx;
  logic [7:0] acc_wdata;
  // answers and allocation status
  logic rsp_valid;
  logic rsp_err;
  logic [7:0] rsp_data;
  uefa_sum_t alloc_used;
  logic alloc_err;

  modport dev (
    input clk_i, rst_i, cfg_wr, cfg_idx, cfg_data, dma_en, dma_idx,
    input acc_valid, acc_write, acc_dma, acc_idx, acc_wdata,
    output acc_ready, rsp_valid, rsp_err, rsp_data, alloc_used, alloc_err
  );
  modport ctl (
    input clk_i, rst_i, acc_ready, rsp_valid, rsp_err, rsp_data, alloc_used, alloc_err,
    output cfg_wr, cfg_idx, cfg_data, dma_en, dma_idx,
    output acc_valid, acc_write, acc_dma, acc_idx, acc_wdata
  );
endinterface

// ---- core/uefa_fifo.sv ----
`timescale 1ns/1ps
module uefa_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // levels
  output logic empty_o,
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] level;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign level = wptr - rptr;
  assign full_o = (level == (AW+1)'(DEPTH));
  assign empty_o = (level == '0);
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o = mem[rptr[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule

// ---- core/uefa_dev.sv ----
`timescale 1ns/1ps
`include "uefa_cfg.svh"
module uefa_dev
  import uefa_pkg::*;
(
  // link to the controller
  uefa_link_if.dev link,
  // usb bus reset from the serial engine
  input wire logic usb_reset_i,
  // received bytes from the serial engine
  input wire logic usb_rx_valid_i,
  input wire uefa_idx_t usb_rx_ep_i,
  input wire logic [7:0] usb_rx_data_i,
  output logic usb_rx_ready_o,
  output logic usb_rx_done_o,
  output logic usb_rx_err_o,
  // bytes to transmit to the serial engine
  input wire logic usb_tx_req_i,
  input wire uefa_idx_t usb_tx_ep_i,
  output logic usb_tx_ready_o,
  output logic usb_tx_valid_o,
  output logic usb_tx_err_o,
  output logic [7:0] usb_tx_data_o
);
  localparam int NEP = `UEFA_NUM_EP;

  ////////////////////////////////////////////////////////////////////////////
  // configuration and allocation

  uefa_ecr_s endpoint_config_reg [NEP];
  uefa_len_t phys [NEP];
  uefa_sum_t base [NEP];
  uefa_sum_t top [NEP];
  uefa_len_t wptr [NEP];
  uefa_len_t rptr [NEP];
  uefa_len_t cnt [NEP];
  logic [NEP-1:0] usable;
  logic [NEP-1:0] is_in;
  logic [NEP-1:0] bad_code;
  logic [7:0] mem [`UEFA_STORE_BYTES];

  wire clr = link.rst_i | usb_reset_i;
  wire cfg_hit = link.cfg_wr & (link.cfg_idx >= `UEFA_IDX_FIRST_CFG);
  uefa_ecr_s cfg_new;
  assign cfg_new = uefa_ecr_s'(link.cfg_data);
  wire cfg_alloc_chg = cfg_hit & ({cfg_new.en, cfg_new.dbl, cfg_new.iso, cfg_new.size} !=
    {endpoint_config_reg[link.cfg_idx].en, endpoint_config_reg[link.cfg_idx].dbl, endpoint_config_reg[link.cfg_idx].iso,
    endpoint_config_reg[link.cfg_idx].size});
  // contents are dropped rather than left to alias a moved region
  wire flush = clr | cfg_alloc_chg;

  function automatic uefa_len_t log_size(input logic iso, input logic [3:0] code);
    uefa_len_t s;
    s = '0;
    if (iso)
    begin
      unique case (code)
        4'h0: s = 12'd16;
        4'h1: s = 12'd32;
        4'h2: s = 12'd48;
        4'h3: s = 12'd64;
        4'h4: s = 12'd96;
        4'h5: s = 12'd128;
        4'h6: s = 12'd160;
        4'h7: s = 12'd192;
        4'h8: s = 12'd256;
        4'h9: s = 12'd320;
        4'ha: s = 12'd384;
        4'hb: s = 12'd512;
        4'hc: s = 12'd640;
        4'hd: s = 12'd768;
        4'he: s = 12'd896;
        4'hf: s = 12'd1023;
      endcase
    end
    else if (code < `UEFA_NONISO_CODES)
    begin
      s = 12'd8 << code[1:0];
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request slots: one pending request per source, ready means slot free

  logic rx_free;
  uefa_idx_t rx_ep;
  logic [7:0] rx_data;
  logic tx_free;
  uefa_idx_t tx_ep;
  logic acc_free;
  logic acc_write;
  logic acc_bad;
  uefa_idx_t acc_ep;
  logic [7:0] acc_data;

  // the control endpoint is never a dma target
  wire dma_bad = ~link.dma_en | (link.dma_idx < `UEFA_IDX_FIRST_CFG);
  wire uefa_idx_t acc_ep_in = link.acc_dma ? link.dma_idx : link.acc_idx;

  // serial engine first: it cannot wait, firmware can
  wire sel_rx = ~rx_free;
  wire sel_tx = ~tx_free & rx_free;
  wire sel_acc = ~acc_free & rx_free & tx_free;
  wire uefa_idx_t op_ep = sel_rx ? rx_ep : (sel_tx ? tx_ep : acc_ep);
  wire op_push = sel_rx | (sel_acc & acc_write);
  wire op_need_in = sel_tx | (sel_acc & acc_write);
  wire room_ok = op_push ? (cnt[op_ep] < phys[op_ep]) : (cnt[op_ep] != '0);
  wire op_ok = (sel_rx | sel_tx | sel_acc) & usable[op_ep] & ~(sel_acc & acc_bad) &
    (is_in[op_ep] == op_need_in) & room_ok & ~flush;
  wire [7:0] op_wdata = sel_rx ? rx_data : acc_data;
  wire uefa_len_t op_addr = 12'(base[op_ep]) + (op_push ? wptr[op_ep] : rptr[op_ep]);
  wire [7:0] op_rdata = mem[op_addr];

  ////////////////////////////////////////////////////////////////////////////
  // per-endpoint configuration, region and ring state

  genvar i;
  generate
    for (i = 0; i < NEP; i++)
    begin : g_ep
      uefa_len_t lsz;
      uefa_len_t nxt_w;
      uefa_len_t nxt_r;
      wire hit = op_ok & (op_ep == i[3:0]);
      if (i < 2)
      begin : g_ctrl
        assign lsz = `UEFA_CTRL_BYTES;
        assign phys[i] = lsz;
        assign is_in[i] = (i[3:0] == `UEFA_IDX_CTRL_IN);
        assign bad_code[i] = 1'b0;
        always_ff @(posedge link.clk_i)
        begin
          endpoint_config_reg[i] <= uefa_ecr_s'(`UEFA_ECR_RST);
        end
      end
      else
      begin : g_cfg
        assign lsz = log_size(endpoint_config_reg[i].iso, endpoint_config_reg[i].size);
        assign phys[i] = ~endpoint_config_reg[i].en ? '0 : (endpoint_config_reg[i].dbl ? lsz << 1 : lsz);
        assign is_in[i] = endpoint_config_reg[i].dir;
        assign bad_code[i] = endpoint_config_reg[i].en & (lsz == '0);
        always_ff @(posedge link.clk_i)
        begin
          if (clr)
          begin
            endpoint_config_reg[i] <= uefa_ecr_s'(`UEFA_ECR_RST);
          end
          else if (cfg_hit & (link.cfg_idx == i[3:0]))
          begin
            endpoint_config_reg[i] <= cfg_new;
          end
        end
      end
      if (i == 0)
      begin : g_first
        assign base[i] = '0;
      end
      else
      begin : g_next
        assign base[i] = top[i-1];
      end
      assign top[i] = base[i] + 16'(phys[i]);
      assign usable[i] = (phys[i] != '0) & (top[i] <= `UEFA_STORE_BYTES);
      assign nxt_w = (wptr[i] + 1'b1 == phys[i]) ? '0 : wptr[i] + 1'b1;
      assign nxt_r = (rptr[i] + 1'b1 == phys[i]) ? '0 : rptr[i] + 1'b1;

      always_ff @(posedge link.clk_i)
      begin
        if (flush)
        begin
          wptr[i] <= '0;
          rptr[i] <= '0;
          cnt[i] <= '0;
        end
        else if (hit & op_push)
        begin
          wptr[i] <= nxt_w;
          cnt[i] <= cnt[i] + 1'b1;
        end
        else if (hit)
        begin
          rptr[i] <= nxt_r;
          cnt[i] <= cnt[i] - 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // shared store and status

  always_ff @(posedge link.clk_i)
  begin
    if (op_ok & op_push)
    begin
      mem[op_addr] <= op_wdata;
    end
  end

  always_ff @(posedge link.clk_i)
  begin
    if (link.rst_i)
    begin
      link.alloc_used <= '0;
      link.alloc_err <= 1'b0;
    end
    else
    begin
      link.alloc_used <= top[NEP-1];
      // overcommit is reported here; an endpoint whose region ends past the store is made unusable
      link.alloc_err <= (top[NEP-1] > `UEFA_STORE_BYTES) | (|bad_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot capture and answers

  always_ff @(posedge link.clk_i)
  begin
    if (link.rst_i)
    begin
      rx_free <= 1'b1;
      tx_free <= 1'b1;
      acc_free <= 1'b1;
      usb_rx_done_o <= 1'b0;
      usb_rx_err_o <= 1'b0;
      usb_tx_valid_o <= 1'b0;
      usb_tx_err_o <= 1'b0;
      usb_tx_data_o <= 8'h00;
      link.rsp_valid <= 1'b0;
      link.rsp_err <= 1'b0;
      link.rsp_data <= 8'h00;
    end
    else
    begin
      usb_rx_done_o <= sel_rx & op_ok;
      usb_rx_err_o <= sel_rx & ~op_ok;
      usb_tx_valid_o <= sel_tx & op_ok;
      usb_tx_err_o <= sel_tx & ~op_ok;
      link.rsp_valid <= sel_acc;
      link.rsp_err <= sel_acc & ~op_ok;
      if (sel_tx & op_ok)
      begin
        usb_tx_data_o <= op_rdata;
      end
      if (sel_acc)
      begin
        link.rsp_data <= (op_ok & ~acc_write) ? op_rdata : 8'h00;
      end
      if (rx_free & usb_rx_valid_i)
      begin
        rx_free <= 1'b0;
      end
      else if (sel_rx)
      begin
        rx_free <= 1'b1;
      end
      if (tx_free & usb_tx_req_i)
      begin
        tx_free <= 1'b0;
      end
      else if (sel_tx)
      begin
        tx_free <= 1'b1;
      end
      if (acc_free & link.acc_valid)
      begin
        acc_free <= 1'b0;
      end
      else if (sel_acc)
      begin
        acc_free <= 1'b1;
      end
    end
  end

  always_ff @(posedge link.clk_i)
  begin
    if (rx_free)
    begin
      rx_ep <= usb_rx_ep_i;
      rx_data <= usb_rx_data_i;
    end
    if (tx_free)
    begin
      tx_ep <= usb_tx_ep_i;
    end
    if (acc_free)
    begin
      acc_ep <= acc_ep_in;
      acc_write <= link.acc_write;
      acc_data <= link.acc_wdata;
      acc_bad <= link.acc_dma & dma_bad;
    end
  end

  assign usb_rx_ready_o = rx_free;
  assign usb_tx_ready_o = tx_free;
  assign link.acc_ready = acc_free;
endmodule

// ---- core/uefa_ctl.sv ----
`timescale 1ns/1ps
`include "uefa_cfg.svh"
module uefa_ctl
  import uefa_pkg::*;
#(
  parameter int DEPTH = `UEFA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link to the endpoint device
  uefa_link_if.ctl link
);
  logic [11:0] ecr_last;
  logic [4:0] acc_sel;
  logic acc_err;
  logic inflight;
  uefa_rd_e rd_state;
  logic q_ready;
  logic q_valid;
  logic q_empty;
  logic q_full;
  logic [12:0] q_data;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire lane0 = wb_sel_i[0];
  wire hit_ecr = (wb_adr_i == `UEFA_REG_ECR);
  wire hit_dma = (wb_adr_i == `UEFA_REG_DMA);
  wire hit_sel = (wb_adr_i == `UEFA_REG_SEL);
  wire hit_data = (wb_adr_i == `UEFA_REG_DATA);
  wire hit_stat = (wb_adr_i == `UEFA_REG_STAT);
  wire q_push = wr & hit_data & lane0 & q_ready;
  wire load = q_valid & (~link.acc_valid | link.acc_ready);
  wire launch = req & ~wb_we_i & hit_data & (rd_state == RD_IDLE) & q_empty &
    ~link.acc_valid & ~inflight;
  wire data_ack = wb_we_i ? (q_ready | ~lane0) : (rd_state == RD_DONE);
  wire go_ack = req & (hit_data ? data_ack : 1'b1);
  wire [31:0] stat_word = {12'h000, q_full, q_empty, acc_err, link.alloc_err, link.alloc_used};

  ////////////////////////////////////////////////////////////////////////////
  // write data queue: a full queue holds the bus ack back

  uefa_fifo #(
    .WIDTH(13),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(q_push),
    .in_ready_o(q_ready),
    .in_data_i({acc_sel, wb_dat_i[7:0]}),
    .out_valid_o(q_valid),
    .out_ready_i(load),
    .out_data_o(q_data),
    .empty_o(q_empty),
    .full_o(q_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers and link drive

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ecr_last <= 12'h000;
      acc_sel <= 5'h00;
      acc_err <= 1'b0;
      inflight <= 1'b0;
      rd_state <= RD_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      link.cfg_wr <= 1'b0;
      link.cfg_idx <= 4'h0;
      link.cfg_data <= 8'h00;
      link.dma_en <= 1'b0;
      link.dma_idx <= 4'h0;
      link.acc_valid <= 1'b0;
      link.acc_write <= 1'b0;
      link.acc_dma <= 1'b0;
      link.acc_idx <= 4'h0;
      link.acc_wdata <= 8'h00;
    end
    else
    begin
      wb_ack_o <= go_ack;
      link.cfg_wr <= 1'b0;
      // each bus write to the ECR with byte lanes 0 and 1 becomes one config write, in the order software issues them
      if (wr & hit_ecr & (&wb_sel_i[1:0]))
      begin
        ecr_last <= wb_dat_i[11:0];
        link.cfg_wr <= 1'b1;
        link.cfg_idx <= wb_dat_i[11:8];
        link.cfg_data <= wb_dat_i[7:0];
      end
      if (wr & hit_dma & lane0)
      begin
        link.dma_en <= wb_dat_i[4];
        link.dma_idx <= wb_dat_i[3:0];
      end
      if (wr & hit_sel & lane0)
      begin
        acc_sel <= wb_dat_i[4:0];
      end
      // a new error beats a clear in the same cycle
      if (link.rsp_valid & link.rsp_err)
      begin
        acc_err <= 1'b1;
      end
      else if (wr & hit_stat & wb_sel_i[2] & wb_dat_i[`UEFA_ST_ACC_ERR])
      begin
        acc_err <= 1'b0;
      end
      if ((link.acc_valid & link.acc_ready) | launch)
      begin
        inflight <= 1'b1;
      end
      else if (link.rsp_valid)
      begin
        inflight <= 1'b0;
      end
      if (load)
      begin
        link.acc_valid <= 1'b1;
        link.acc_write <= 1'b1;
        {link.acc_dma, link.acc_idx, link.acc_wdata} <= q_data;
      end
      else if (launch)
      begin
        link.acc_valid <= 1'b1;
        link.acc_write <= 1'b0;
        {link.acc_dma, link.acc_idx} <= acc_sel;
      end
      else if (link.acc_ready)
      begin
        link.acc_valid <= 1'b0;
      end
      unique case (rd_state)
        RD_IDLE:
        begin
          if (launch)
          begin
            rd_state <= RD_WAIT;
          end
        end
        RD_WAIT:
        begin
          if (link.rsp_valid)
          begin
            rd_state <= RD_DONE;
            wb_dat_o <= {24'h000000, link.rsp_data};
          end
        end
        RD_DONE:
        begin
          rd_state <= RD_IDLE;
        end
      endcase
      if (go_ack & ~wb_we_i & ~hit_data)
      begin
        wb_dat_o <= hit_ecr ? {20'h00000, ecr_last} :
          hit_dma ? {27'h0000000, link.dma_en, link.dma_idx} :
          hit_sel ? {27'h0000000, acc_sel} :
          hit_stat ? stat_word : 32'h0000_0000;
      end
    end
  end
endmodule

// ---- dv/uefa_link_monitor.sv ----
`timescale 1ns/1ps
module uefa_link_monitor
  import uefa_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic dma_en,
  input wire uefa_idx_t dma_idx,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire logic acc_dma,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire uefa_sum_t alloc_used,
  input wire logic alloc_err
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire take = acc_valid && acc_ready;
  ////////////////////////////////////////////////////////////
  a_dma_bad_refused: assert property (
    take && acc_dma && (!dma_en || dma_idx < 4'h2) |-> ##[2:20] (rsp_valid && rsp_err))
    else $error("dma access to unusable endpoint not refused");
  a_alloc_after_reset: assert property (
    $fell(rst_i) |=> alloc_used == 16'd128)
    else $error("allocation not back to control pair after reset");
  a_ctrl_floor: assert property (
    !$past(rst_i) |-> alloc_used >= 16'd128)
    else $error("control buffers missing from allocation");
  a_over_flagged: assert property (
    alloc_used > 16'd2462 |-> alloc_err)
    else $error("allocation beyond store not flagged");
  a_take_answered: assert property (
    take |-> ##[2:20] rsp_valid)
    else $error("accepted access got no answer");
  a_ready_drops: assert property (
    take |=> !acc_ready)
    else $error("second access accepted while one is outstanding");
  a_rsp_single: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("answer lasted more than one cycle");
  a_ready_returns: assert property (
    !acc_ready |-> ##[1:20] acc_ready)
    else $error("link stayed busy");
endmodule

// ---- dv/usb_endpoint_fifo_allocator_tb.sv ----
`timescale 1ns/1ps
`include "uefa_cfg.svh"
module usb_endpoint_fifo_allocator_tb;
  import uefa_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic usb_reset_i = 1'h0;
  logic usb_rx_valid_i = 1'h0;
  uefa_idx_t usb_rx_ep_i = 4'h0;
  logic [7:0] usb_rx_data_i = 8'h00;
  logic usb_rx_ready_o, usb_rx_done_o, usb_rx_err_o;
  logic usb_tx_req_i = 1'h0;
  uefa_idx_t usb_tx_ep_i = 4'h0;
  logic usb_tx_ready_o, usb_tx_valid_o, usb_tx_err_o;
  logic [7:0] usb_tx_data_o;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] q;
  int iso_sz[16] = '{16, 32, 48, 64, 96, 128, 160, 192, 256, 320, 384, 512, 640, 768, 896, 1023};
  logic [7:0] tbl_ecr[16] = '{8'h00, 8'h00, 8'hdf, 8'h81, 8'ha1, 8'hc3, 8'he3, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #5 clk_i = ~clk_i;

  uefa_link_if link (.clk_i(clk_i), .rst_i(rst_i));
  uefa_ctl u_uefa_ctl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link));
  uefa_dev u_uefa_dev (.link(link), .usb_reset_i(usb_reset_i), .usb_rx_valid_i(usb_rx_valid_i),
    .usb_rx_ep_i(usb_rx_ep_i), .usb_rx_data_i(usb_rx_data_i), .usb_rx_ready_o(usb_rx_ready_o),
    .usb_rx_done_o(usb_rx_done_o), .usb_rx_err_o(usb_rx_err_o), .usb_tx_req_i(usb_tx_req_i),
    .usb_tx_ep_i(usb_tx_ep_i), .usb_tx_ready_o(usb_tx_ready_o),
    .usb_tx_valid_o(usb_tx_valid_o), .usb_tx_err_o(usb_tx_err_o),
    .usb_tx_data_o(usb_tx_data_o));
  uefa_link_monitor u_uefa_link_monitor (.clk_i(link.clk_i), .rst_i(link.rst_i),
    .dma_en(link.dma_en), .dma_idx(link.dma_idx), .acc_valid(link.acc_valid),
    .acc_ready(link.acc_ready), .acc_dma(link.acc_dma), .rsp_valid(link.rsp_valid),
    .rsp_err(link.rsp_err), .alloc_used(link.alloc_used), .alloc_err(link.alloc_err));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // the watchdog is the only bound on these waits
  task automatic wb(input logic we, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic cfg(input uefa_idx_t i, input logic [7:0] v);
    wb(1'h1, `UEFA_REG_ECR, 4'h3, {20'h0, i, v});
  endtask

  task automatic stat_chk(input logic [16:0] exp);
    wb(1'h0, `UEFA_REG_STAT, 4'hf, 32'h0);
    chk({15'h0, q[16:0]}, {15'h0, exp});
  endtask

  // queued data writes reach the link late, so drain before judging
  task automatic acc_chk(input logic e);
    do wb(1'h0, `UEFA_REG_STAT, 4'hf, 32'h0); while (q[`UEFA_ST_EMPTY] !== 1'h1);
    repeat (4) @(posedge clk_i);
    wb(1'h0, `UEFA_REG_STAT, 4'hf, 32'h0);
    chk({31'h0, q[`UEFA_ST_ACC_ERR]}, {31'h0, e});
    wb(1'h1, `UEFA_REG_STAT, 4'h4, 32'h0002_0000);
  endtask

  task automatic sel_ep(input logic [4:0] v);
    wb(1'h1, `UEFA_REG_SEL, 4'h1, {27'h0, v});
  endtask

  task automatic dat_wr(input logic [7:0] b);
    wb(1'h1, `UEFA_REG_DATA, 4'h1, {24'h0, b});
  endtask

  task automatic usb_tx(input uefa_idx_t e, input logic [7:0] exp, input logic ok);
    @(posedge clk_i);
    usb_tx_req_i <= 1'h1;
    usb_tx_ep_i <= e;
    do @(posedge clk_i); while (usb_tx_ready_o !== 1'h1);
    usb_tx_req_i <= 1'h0;
    do @(posedge clk_i); while (usb_tx_valid_o !== 1'h1 && usb_tx_err_o !== 1'h1);
    chk({31'h0, usb_tx_err_o}, {31'h0, !ok});
    if (ok)
      chk({24'h0, usb_tx_data_o}, {24'h0, exp});
  endtask

  task automatic usb_rx(input uefa_idx_t e, input logic [7:0] b, input logic ok);
    @(posedge clk_i);
    usb_rx_valid_i <= 1'h1;
    usb_rx_ep_i <= e;
    usb_rx_data_i <= b;
    do @(posedge clk_i); while (usb_rx_ready_o !== 1'h1);
    usb_rx_valid_i <= 1'h0;
    do @(posedge clk_i); while (usb_rx_done_o !== 1'h1 && usb_rx_err_o !== 1'h1);
    chk({31'h0, usb_rx_err_o}, {31'h0, !ok});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    stat_chk(17'h00080);
    wb(1'h1, 5'h14, 4'hf, 32'hffff_ffff);
    wb(1'h0, 5'h14, 4'hf, 32'h0);
    chk(q, 32'h0);
    cfg(4'hf, 8'h80);
    wb(1'h0, `UEFA_REG_ECR, 4'hf, 32'h0);
    chk({20'h0, q[11:0]}, 32'hf80);
    stat_chk(17'h00088);
    cfg(4'hf, 8'h00);
  endtask

  task automatic t_sizes;
    for (int c = 0; c < 4; c++)
    begin
      cfg(4'h2, 8'h80 | c[7:0]);
      stat_chk(17'(128 + (8 << c)));
    end
    cfg(4'h2, 8'h84);
    stat_chk(17'h10080);
    for (int c = 0; c < 16; c++)
    begin
      cfg(4'h2, 8'h90 | c[7:0]);
      stat_chk(17'(128 + iso_sz[c]));
    end
    cfg(4'h2, 8'hd3);
    stat_chk(17'(128 + 128));
    cfg(4'h2, 8'h00);
    stat_chk(17'h00080);
  endtask

  // exact fit of the whole shared store, then one endpoint too many
  task automatic t_table;
    // all sixteen registers in endpoint order, disabled ones too
    for (int e = 0; e < 16; e++)
      cfg(e[3:0], tbl_ecr[e]);
    // firmware judges success from this status before answering the host
    stat_chk(17'(2462));
    cfg(4'h7, 8'h80);
    wb(1'h0, `UEFA_REG_STAT, 4'hf, 32'h0);
    chk({31'h0, q[`UEFA_ST_ALLOC_ERR]}, 32'h1);
    cfg(4'h7, 8'h00);
    stat_chk(17'(2462));
  endtask

  task automatic t_io;
    sel_ep(5'h04);
    for (int i = 0; i < 16; i++)
      dat_wr(i[7:0]);
    acc_chk(1'h0);
    dat_wr(8'hee);
    acc_chk(1'h1);
    for (int i = 0; i < 16; i++)
      usb_tx(4'h4, i[7:0], 1'h1);
    usb_tx(4'h4, 8'h00, 1'h0);
    usb_rx(4'h4, 8'h55, 1'h0);
    usb_rx(4'h3, 8'ha5, 1'h1);
    usb_rx(4'h3, 8'h5a, 1'h1);
    sel_ep(5'h03);
    wb(1'h0, `UEFA_REG_DATA, 4'h1, 32'h0);
    chk({24'h0, q[7:0]}, 32'ha5);
    wb(1'h0, `UEFA_REG_DATA, 4'h1, 32'h0);
    chk({24'h0, q[7:0]}, 32'h5a);
    dat_wr(8'h11);
    acc_chk(1'h1);
    sel_ep(5'h04);
    dat_wr(8'h22);
    cfg(4'h5, 8'hc2);
    usb_tx(4'h4, 8'h00, 1'h0);
  endtask

  task automatic t_dma;
    wb(1'h1, `UEFA_REG_DMA, 4'h1, 32'h04);
    sel_ep(5'h10);
    dat_wr(8'h01);
    acc_chk(1'h1);
    wb(1'h1, `UEFA_REG_DMA, 4'h1, 32'h14);
    dat_wr(8'h02);
    acc_chk(1'h0);
    usb_tx(4'h4, 8'h02, 1'h1);
    wb(1'h1, `UEFA_REG_DMA, 4'h1, 32'h11);
    dat_wr(8'h03);
    acc_chk(1'h1);
    sel_ep(5'h01);
    for (int i = 0; i < 64; i++)
      dat_wr(i[7:0]);
    acc_chk(1'h0);
    dat_wr(8'h40);
    acc_chk(1'h1);
    usb_tx(4'h1, 8'h00, 1'h1);
  endtask

  task automatic t_usb_rst;
    @(posedge clk_i);
    usb_reset_i <= 1'h1;
    @(posedge clk_i);
    usb_reset_i <= 1'h0;
    stat_chk(17'h00080);
    usb_tx(4'h1, 8'h00, 1'h0);
    usb_rx(4'h0, 8'h77, 1'h1);
    sel_ep(5'h00);
    wb(1'h0, `UEFA_REG_DATA, 4'h1, 32'h0);
    chk({24'h0, q[7:0]}, 32'h77);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_sizes;
    t_table;
    t_io;
    t_dma;
    t_usb_rst;
    complete_run;
  end

  // the sequence needs well under 20000 cycles
  initial
  begin
    #900000;
    error_cnt++;
    complete_run;
  end
endmodule
